// ### rtl/cmbt_accept.sv
// Identifier acceptance compare for one mask set
`timescale 1ns/1ns
`include "cmbt_regs.svh"
module cmbt_accept (
  input wire logic [28:0] rx_ident,
  input wire logic rx_extended,
  input wire logic [28:0] filter_ident,
  input wire logic filter_extended,
  input wire logic [28:0] ident_mask,
  input wire logic frame_type_mask,
  output logic accept
);
  import cmbt_pkg::*;
  logic [28:0] diff;
  logic type_ok;
  // Masked compare; a zero mask bit is a don't-care
  always_comb begin
    diff = (rx_ident ^ filter_ident) & ident_mask;
    if (frame_type_mask) begin
      type_ok = (rx_extended == filter_extended);
    end else begin
      type_ok = 1'b1;
    end
    accept = type_ok && (diff == 29'h0);
  end
endmodule

// ### rtl/cmbt_mask_timing.sv
// AXI4-Lite register block for acceptance masks and first bit-timing register
`timescale 1ns/1ns
`include "cmbt_regs.svh"
module cmbt_mask_timing (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [28:0] rx_ident,
  input wire logic rx_extended,
  input wire logic [28:0] filter_ident0,
  input wire logic filter_extended0,
  input wire logic [28:0] filter_ident1,
  input wire logic filter_extended1,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  output logic [1:0] accept,
  output logic [2:0] resync_jump_width,
  output logic [5:0] quantum_prescaler,
  output logic tq_tick,
  output logic stuff_bit_next
);
  import cmbt_pkg::*;

  typedef struct packed {
    cmbt_bus_state_t wst;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] bresp;
    logic ar_busy;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] std_low0;
    logic [7:0] ext_high0;
    logic [7:0] ext_low0;
    logic [7:0] std_low1;
    logic [7:0] ext_high1;
    logic [7:0] ext_low1;
    logic [7:0] timing;
    logic [7:0] ctrl;
    logic wr_refused;
    logic [1:0] accept;
    logic last_bit;
    logic [2:0] run_len;
    logic stuff_next;
    logic [2:0] jump_w;
    logic tq;
  } cmbt_state_t;

  cmbt_state_t st_reg, st_next;
  logic tq_raw;
  logic [1:0] acc_raw;
  logic [28:0] mask0, mask1;
  logic enh_mode;
  logic [7:0] std_rd0, std_rd1;

  // Enhanced modes 1 to 3 (any nonzero mode) enable the frame-type mask bit
  assign enh_mode = (st_reg.ctrl[`CMBT_CTRL_MODE_LSB+1:`CMBT_CTRL_MODE_LSB] != 2'b00);
  assign std_rd0 = st_reg.std_low0 & `CMBT_STD_LOW_RW_MASK |
    {4'h0, enh_mode & st_reg.std_low0[`CMBT_FTYPE_BIT], 3'h0};
  assign std_rd1 = st_reg.std_low1 & `CMBT_STD_LOW_RW_MASK |
    {4'h0, enh_mode & st_reg.std_low1[`CMBT_FTYPE_BIT], 3'h0};

  // Assemble 29-bit masks: ext ident 28-21 is outside this block, taken as care
  assign mask0 = {8'hff, st_reg.std_low0[7:5], st_reg.std_low0[1:0],
    st_reg.ext_high0, st_reg.ext_low0};
  assign mask1 = {8'hff, st_reg.std_low1[7:5], st_reg.std_low1[1:0],
    st_reg.ext_high1, st_reg.ext_low1};

  // Byte-lane merge of a write word into an 8-bit register
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction

  // Register file, bus engine and stuff-run tracker
  always_comb begin
    st_next = st_reg;
    st_next.accept = acc_raw;
    st_next.tq = tq_raw;
    // Write address and data channels taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    case (st_reg.wst)
      CMBT_IDLE: begin
        if (st_reg.aw_got && st_reg.w_got) begin
          st_next.wst = CMBT_RESP;
          st_next.bresp = 2'b00;
          st_next.wr_refused = 1'b0;
          case (st_reg.aw_addr)
            `CMBT_OFF_STD_LOW0: st_next.std_low0 = lane0(st_reg.std_low0, st_reg.w_data,
                                                        st_reg.w_strb);
            `CMBT_OFF_EXT_HIGH0: st_next.ext_high0 = lane0(st_reg.ext_high0, st_reg.w_data,
                                                          st_reg.w_strb);
            `CMBT_OFF_EXT_LOW0: st_next.ext_low0 = lane0(st_reg.ext_low0, st_reg.w_data,
                                                        st_reg.w_strb);
            `CMBT_OFF_STD_LOW1: st_next.std_low1 = lane0(st_reg.std_low1, st_reg.w_data,
                                                        st_reg.w_strb);
            `CMBT_OFF_EXT_HIGH1: st_next.ext_high1 = lane0(st_reg.ext_high1, st_reg.w_data,
                                                          st_reg.w_strb);
            `CMBT_OFF_EXT_LOW1: st_next.ext_low1 = lane0(st_reg.ext_low1, st_reg.w_data,
                                                        st_reg.w_strb);
            `CMBT_OFF_TIMING: begin
              if (st_reg.ctrl[`CMBT_CTRL_CONFIG_BIT]) begin
                st_next.timing = lane0(st_reg.timing, st_reg.w_data, st_reg.w_strb);
              end else begin
                st_next.wr_refused = 1'b1;
                st_next.bresp = 2'b10;
              end
            end
            `CMBT_OFF_CTRL: st_next.ctrl = lane0(st_reg.ctrl, st_reg.w_data, st_reg.w_strb)
                                           & 8'h07;
            `CMBT_OFF_STATUS: st_next.bresp = 2'b00;
            default: st_next.bresp = 2'b10;
          endcase
        end
      end
      CMBT_RESP: begin
        if (s_axi_bready) begin
          st_next.wst = CMBT_IDLE;
          st_next.aw_got = 1'b0;
          st_next.w_got = 1'b0;
        end
      end
      default: st_next.wst = CMBT_IDLE;
    endcase
    // Read channel: one read in flight
    if (!st_reg.ar_busy && s_axi_arvalid) begin
      st_next.ar_busy = 1'b1;
      st_next.rresp = 2'b00;
      case (s_axi_araddr)
        `CMBT_OFF_STD_LOW0: st_next.rdata = {24'h0, std_rd0};
        `CMBT_OFF_EXT_HIGH0: st_next.rdata = {24'h0, st_reg.ext_high0};
        `CMBT_OFF_EXT_LOW0: st_next.rdata = {24'h0, st_reg.ext_low0};
        `CMBT_OFF_STD_LOW1: st_next.rdata = {24'h0, std_rd1};
        `CMBT_OFF_EXT_HIGH1: st_next.rdata = {24'h0, st_reg.ext_high1};
        `CMBT_OFF_EXT_LOW1: st_next.rdata = {24'h0, st_reg.ext_low1};
        `CMBT_OFF_TIMING: st_next.rdata = {24'h0, st_reg.timing};
        `CMBT_OFF_CTRL: st_next.rdata = {24'h0, st_reg.ctrl};
        `CMBT_OFF_STATUS: st_next.rdata = {28'h0, st_reg.stuff_next, st_reg.wr_refused,
                                           st_reg.accept};
        default: begin
          st_next.rdata = 32'h0;
          st_next.rresp = 2'b10;
        end
      endcase
    end else if (st_reg.ar_busy && s_axi_rready) begin
      st_next.ar_busy = 1'b0;
    end
    // Count equal bits; after five the next bit must be a stuff bit
    if (rx_bit_valid) begin
      if (st_reg.stuff_next) begin
        st_next.run_len = 3'd1;
        st_next.stuff_next = 1'b0;
      end else if (rx_bit == st_reg.last_bit) begin
        st_next.run_len = st_reg.run_len + 3'd1;
        st_next.stuff_next = (st_reg.run_len + 3'd1 == `CMBT_STUFF_RUN);
      end else begin
        st_next.run_len = 3'd1;
      end
      st_next.last_bit = rx_bit;
    end
    // Jump width held in its own flop, tracking the timing byte
    st_next.jump_w = {1'b0, st_next.timing[7:6]} + 3'd1;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.wst <= CMBT_IDLE;
      st_reg.timing <= `CMBT_TIMING_RESET;
      st_reg.ctrl <= `CMBT_CTRL_RESET;
      st_reg.last_bit <= 1'b1;
      st_reg.jump_w <= 3'd1; // Zero jump field gives one quantum
    end else begin
      st_reg <= st_next;
    end
  end

  // Quantum generator and two acceptance comparators
  cmbt_tq_gen u_tq (
    .aclk(aclk),
    .aresetn(aresetn),
    .quantum_prescaler(st_reg.timing[5:0]),
    .tq_tick(tq_raw)
  );
  cmbt_accept u_acc0 (
    .rx_ident(rx_ident),
    .rx_extended(rx_extended),
    .filter_ident(filter_ident0),
    .filter_extended(filter_extended0),
    .ident_mask(mask0),
    .frame_type_mask(enh_mode & st_reg.std_low0[`CMBT_FTYPE_BIT]),
    .accept(acc_raw[0])
  );
  cmbt_accept u_acc1 (
    .rx_ident(rx_ident),
    .rx_extended(rx_extended),
    .filter_ident(filter_ident1),
    .filter_extended(filter_extended1),
    .ident_mask(mask1),
    .frame_type_mask(enh_mode & st_reg.std_low1[`CMBT_FTYPE_BIT]),
    .accept(acc_raw[1])
  );

  // Outputs straight from flip-flops
  assign s_axi_awready = !st_reg.aw_got && (st_reg.wst == CMBT_IDLE);
  assign s_axi_wready = !st_reg.w_got && (st_reg.wst == CMBT_IDLE);
  assign s_axi_bvalid = (st_reg.wst == CMBT_RESP);
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.ar_busy;
  assign s_axi_rvalid = st_reg.ar_busy;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign accept = st_reg.accept;
  assign resync_jump_width = st_reg.jump_w;
  assign quantum_prescaler = st_reg.timing[5:0];
  assign tq_tick = st_reg.tq;
  assign stuff_bit_next = st_reg.stuff_next;

  // Checks
  property p_jump;
    @(posedge aclk) disable iff (!aresetn)
      resync_jump_width == {1'b0, st_reg.timing[7:6]} + 3'd1 && resync_jump_width != 3'd0;
  endproperty
  a_jump: assert property (p_jump) else $error("jump width wrong");
  property p_refuse;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg.wst == CMBT_IDLE && st_reg.aw_got && st_reg.w_got &&
       st_reg.aw_addr == `CMBT_OFF_TIMING && !st_reg.ctrl[0]) |=> $stable(st_reg.timing);
  endproperty
  a_refuse: assert property (p_refuse) else $error("timing written outside config");
  property p_unimpl;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `CMBT_OFF_STD_LOW0)
        |=> s_axi_rdata[4] == 1'b0 && s_axi_rdata[2] == 1'b0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read one");
  property p_ftype;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `CMBT_OFF_STD_LOW1 && !enh_mode)
        |=> s_axi_rdata[3] == 1'b0;
  endproperty
  a_ftype: assert property (p_ftype) else $error("frame-type bit visible in mode 0");
  property p_stuff;
    @(posedge aclk) disable iff (!aresetn)
      stuff_bit_next |-> st_reg.run_len == `CMBT_STUFF_RUN;
  endproperty
  a_stuff: assert property (p_stuff) else $error("stuff flag without five equal bits");
  property p_bhold;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  // Quantum is at least two clocks, so a tick never lasts two cycles
  property p_tick;
    @(posedge aclk) disable iff (!aresetn)
      tq_tick |=> !tq_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("quantum tick too long");
  c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_stuff: cover property (@(posedge aclk) stuff_bit_next);
  c_accept: cover property (@(posedge aclk) accept == 2'b11);
endmodule

// ### rtl/cmbt_pkg.sv
// Types shared by the mask and bit-timing block
package cmbt_pkg;
  typedef enum logic [2:0] {
    CMBT_IDLE = 3'b001,
    CMBT_RESP = 3'b010,
    CMBT_RDAT = 3'b100
  } cmbt_bus_state_t;
  typedef logic [28:0] cmbt_ident_t;
endpackage

// ### rtl/cmbt_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CMBT_REGS_SVH
`define CMBT_REGS_SVH
`define CMBT_OFF_STD_LOW0 8'h00
`define CMBT_OFF_EXT_HIGH0 8'h04
`define CMBT_OFF_EXT_LOW0 8'h08
`define CMBT_OFF_STD_LOW1 8'h0c
`define CMBT_OFF_EXT_HIGH1 8'h10
`define CMBT_OFF_EXT_LOW1 8'h14
`define CMBT_OFF_TIMING 8'h18
`define CMBT_OFF_CTRL 8'h1c
`define CMBT_OFF_STATUS 8'h20
`define CMBT_STD_LOW_RW_MASK 8'he3
`define CMBT_FTYPE_BIT 3
`define CMBT_MASK_RESET 8'h00
`define CMBT_TIMING_RESET 8'h00
`define CMBT_CTRL_CONFIG_BIT 0
`define CMBT_CTRL_MODE_LSB 1
`define CMBT_CTRL_RESET 8'h01
`define CMBT_STUFF_RUN 3'd5
`define CMBT_OSC_NS 8
`endif

// ### rtl/cmbt_tq_gen.sv
// Time-quantum tick generator from the oscillator clock
`timescale 1ns/1ns
`include "cmbt_regs.svh"
module cmbt_tq_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] quantum_prescaler,
  output logic tq_tick
);
  import cmbt_pkg::*;
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } cmbt_tq_st_t;
  cmbt_tq_st_t st_reg, st_next;
  logic [6:0] period_m1;

  // Quantum spans 2 x (prescaler + 1) clock periods
  always_comb begin
    period_m1 = {quantum_prescaler, 1'b1};
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt >= period_m1) begin
      st_next.cnt = 7'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 7'h01;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign tq_tick = st_reg.tick;
endmodule

// ### tb/cmbt_can_node.sv
// Behavioural remote CAN node streaming a stuffed bit sequence
`timescale 1ns/1ns
module cmbt_can_node (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic slow,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic stuff_now
);
  logic [15:0] lfsr_reg;
  logic [2:0] run_reg;
  logic last_reg;
  logic [1:0] gap_reg;
  logic nb;
  // After five equal bits send the opposite bit, else mostly repeat to build long runs
  assign nb = (run_reg == 3'd5) ? ~last_reg : ((lfsr_reg[1:0] != 2'b00) ^ ~last_reg);
  // One bit per slot; between slots the line toggles so stale data never looks valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_reg <= 16'hace1;
      run_reg <= 3'd0;
      last_reg <= 1'b1;
      gap_reg <= 2'd0;
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
      stuff_now <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      if (enable && gap_reg == 2'd0) begin
        rx_bit <= nb;
        rx_bit_valid <= 1'b1;
        stuff_now <= (run_reg == 3'd5);
        run_reg <= (nb == last_reg) ? run_reg + 3'd1 : 3'd1;
        last_reg <= nb;
        gap_reg <= slow ? 2'd3 : 2'd1;
      end else begin
        rx_bit <= ~rx_bit;
        rx_bit_valid <= 1'b0;
        if (gap_reg != 2'd0) gap_reg <= gap_reg - 2'd1;
      end
    end
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the mask and bit-timing register block
`timescale 1ns/1ns
`include "cmbt_regs.svh"
module testbench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rx_ext, f_ext0, f_ext1, rx_bit, rx_bit_valid;
  logic tq_tick, stuff_nx, stuff_now, node_en, slow, re;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, got;
  logic [3:0] wstrb, lane;
  logic [1:0] bresp, rresp, accept, resp, fe, sjw_w;
  logic [28:0] rx_id, f_id0, f_id1, rv;
  logic [28:0] fv [2];
  logic [2:0] jw;
  logic [5:0] qp, brp_w;
  logic [7:0] sl [2], eh [2], el [2];
  int err_total, n_compared, cnt;
  cmbt_mask_timing dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_ident(rx_id), .rx_extended(rx_ext), .filter_ident0(f_id0), .filter_extended0(f_ext0),
    .filter_ident1(f_id1), .filter_extended1(f_ext1), .rx_bit, .rx_bit_valid, .accept,
    .resync_jump_width(jw), .quantum_prescaler(qp), .tq_tick, .stuff_bit_next(stuff_nx));
  cmbt_can_node node (.aclk, .aresetn, .enable(node_en), .slow, .rx_bit, .rx_bit_valid,
    .stuff_now);
  // Free-running 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Readback of the standard low byte: frame-type bit only outside mode 0
  function automatic logic [7:0] sl_exp(input logic [7:0] d, input logic [1:0] m);
    return d & ((m == 2'd0) ? `CMBT_STD_LOW_RW_MASK : (`CMBT_STD_LOW_RW_MASK | 8'h08));
  endfunction
  // Expected acceptance of one mask set; bits 28:21 always compared
  function automatic logic acc_exp(input int s, input logic [1:0] m);
    logic [28:0] k;
    k = {8'hff, sl[s][7:5], sl[s][1:0], eh[s], el[s]};
    return (((rv ^ fv[s]) & k) == 29'h0) && (m == 2'd0 || !sl[s][3] || re == fe[s]);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string msg);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, msg, g, e);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n > 300) begin
      chk(32'h0, 32'h1, "timeout");
      results();
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= lane;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      tmo(n);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      tmo(n);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a, got, resp);
    chk(got, {24'h0, e}, "read data");
    chk({30'h0, resp}, 32'h0, "read resp");
  endtask
  task automatic tick_gap(output int c);
    c = 0;
    do begin
      @(posedge aclk);
      c++;
      tmo(c);
    end while (tq_tick !== 1'b1);
  endtask
  // Bit-stream monitor: the stuff flag must be up exactly when a stuff bit arrives
  always @(posedge aclk) begin
    if (node_en && rx_bit_valid === 1'b1) chk(32'(stuff_nx), 32'(stuff_now), "stuff");
  end
  // Main sequence
  initial begin
    seed = 32'h2e3dea1d;
    err_total = 0;
    n_compared = 0;
    lane = 4'h1;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, node_en, slow} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {rx_id, f_id0, f_id1, rx_ext, f_ext0, f_ext1} = 90'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), `CMBT_MASK_RESET);
    rchk(`CMBT_OFF_TIMING, `CMBT_TIMING_RESET);
    rchk(`CMBT_OFF_CTRL, `CMBT_CTRL_RESET);
    $display("reset test done");
    for (int m = 0; m < 3; m++) begin
      wr(`CMBT_OFF_CTRL, {5'h0, 2'(m), 1'b1}, resp);
      for (int s = 0; s < 2; s++) begin
        sl[s] = (m == 0) ? 8'hff : 8'(rnd());
        eh[s] = 8'(rnd());
        el[s] = 8'(rnd());
        wr(8'(12 * s), sl[s], resp);
        wr(8'(12 * s + 4), eh[s], resp);
        wr(8'(12 * s + 8), el[s], resp);
      end
      for (int s = 0; s < 2; s++) begin
        rchk(8'(12 * s), sl_exp(sl[s], 2'(m)));
        rchk(8'(12 * s + 4), eh[s]);
        rchk(8'(12 * s + 8), el[s]);
      end
      for (int t = 0; t < 24; t++) begin
        fv[0] = 29'(rnd());
        fv[1] = 29'(rnd());
        fe = 2'(rnd());
        re = 1'(rnd());
        rv = (t % 4 != 0) ? fv[t % 2] ^ 29'(rnd() & rnd() & 32'h1fffff) : 29'(rnd());
        rx_id <= rv;
        rx_ext <= re;
        f_id0 <= fv[0];
        f_id1 <= fv[1];
        f_ext0 <= fe[0];
        f_ext1 <= fe[1];
        repeat (2) @(posedge aclk);
        for (int s = 0; s < 2; s++) begin
          chk(32'(accept[s]), 32'(acc_exp(s, 2'(m))), "accept");
        end
      end
    end
    // Byte lane 0 disabled: the register must keep its value
    lane = 4'h0;
    wr(`CMBT_OFF_EXT_HIGH0, ~eh[0], resp);
    lane = 4'h1;
    chk({30'h0, resp}, 32'h0, "masked write resp");
    rchk(`CMBT_OFF_EXT_HIGH0, eh[0]);
    $display("mask test done");
    wr(`CMBT_OFF_CTRL, 8'h01, resp);
    for (int i = 0; i < 5; i++) begin
      sjw_w = 2'(i);
      brp_w = (i == 4) ? 6'(rnd()) : ((i == 3) ? 6'h3f : 6'(i));
      wr(`CMBT_OFF_TIMING, {sjw_w, brp_w}, resp);
      chk({30'h0, resp}, 32'h0, "timing bresp");
      rchk(`CMBT_OFF_TIMING, {sjw_w, brp_w});
      chk(32'(jw), 32'(sjw_w) + 32'h1, "jump width");
      chk(32'(qp), 32'(brp_w), "prescaler");
      tick_gap(cnt);
      tick_gap(cnt);
      chk(32'(cnt), 32'(brp_w) * 32'h2 + 32'h2, "quantum period");
    end
    $display("timing test done");
    wr(`CMBT_OFF_CTRL, 8'h00, resp);
    wr(`CMBT_OFF_TIMING, 8'h5a, resp);
    chk({30'h0, resp}, 32'h2, "refused bresp");
    rchk(`CMBT_OFF_TIMING, {sjw_w, brp_w});
    rd(`CMBT_OFF_STATUS, got, resp);
    chk(32'(got[2]), 32'h1, "refused flag");
    wr(`CMBT_OFF_CTRL, 8'h01, resp);
    rd(8'h24, got, resp);
    chk({30'h0, resp}, 32'h2, "unmapped read resp");
    chk(got, 32'h0, "unmapped read data");
    wr(8'h28, 8'hff, resp);
    chk({30'h0, resp}, 32'h2, "unmapped write resp");
    $display("refusal test done");
    // Reset in mid-run returns timing, masks and mode to their reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(`CMBT_OFF_TIMING, `CMBT_TIMING_RESET);
    rchk(`CMBT_OFF_EXT_LOW1, `CMBT_MASK_RESET);
    rchk(`CMBT_OFF_CTRL, `CMBT_CTRL_RESET);
    chk(32'(jw), 32'h1, "jump width after reset");
    $display("mid-run reset test done");
    node_en <= 1'b1;
    repeat (300) @(posedge aclk);
    slow <= 1'b1;
    repeat (400) @(posedge aclk);
    node_en <= 1'b0;
    @(posedge aclk);
    $display("stuff test done");
    results();
  end
endmodule
